// ### hdl/dsvm_defines.svh
// constants of the drive status and profile velocity block
`ifndef DSVM_DEFINES_SVH
`define DSVM_DEFINES_SVH

// object indices
`define DSVM_IDX_CONTROL   16'h6040
`define DSVM_IDX_STATUS    16'h6041
`define DSVM_IDX_MODE_REQ  16'h6060
`define DSVM_IDX_MODE_ACT  16'h6061
`define DSVM_IDX_VEL_ACT   16'h606c
`define DSVM_IDX_ACCEL     16'h6083
`define DSVM_IDX_DECEL     16'h6084
`define DSVM_IDX_TARGET    16'h60ff
`define DSVM_IDX_WARN      16'h2003

// status word bit positions
`define DSVM_SB_READY      0
`define DSVM_SB_SWON       1
`define DSVM_SB_OPEN       2
`define DSVM_SB_FAULT      3
`define DSVM_SB_HV         4
`define DSVM_SB_QS_N       5
`define DSVM_SB_SOD        6
`define DSVM_SB_WARN       7
`define DSVM_SB_REMOTE     9
`define DSVM_SB_TR         10
`define DSVM_SB_LIMIT      11
`define DSVM_SB_ZERO_SPD   12
`define DSVM_SB_SAFETY     14
`define DSVM_SB_DRV_FAULT  15

// control word halt bit
`define DSVM_CB_HALT       8

// mode codes
`define DSVM_MODE_NONE     8'h00
`define DSVM_MODE_ANALOG   8'h01
`define DSVM_MODE_PV       8'h03
`define DSVM_MODE_MAX      8'h0a

// reset values
`define DSVM_RST_CONTROL   16'h0100
`define DSVM_RST_MODE      8'h00
`define DSVM_RST_RATE      32'h0000_0000

// timing: ramp rates are per second
`define DSVM_CLK_PERIOD_NS 4
`define DSVM_NS_PER_S      1000000000
`define DSVM_CYC_PER_S     (`DSVM_NS_PER_S / `DSVM_CLK_PERIOD_NS)

`endif

// ### hdl/dsvm_pkg.sv
// types of the drive status and profile velocity block
package dsvm_pkg;

	typedef enum logic [2:0] {
		ST_SELFTEST = 3'b001,
		ST_SOD      = 3'b010,
		ST_EXT      = 3'b100
	} dsvm_state_e;

	// power state reported by the control-word state machine
	typedef struct packed {
		logic ready;
		logic switched_on;
		logic op_enabled;
		logic fault;
		logic quick_stop_active;
		logic switch_on_disabled;
	} dsvm_pds_s;

	// object access request
	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] index;
		logic [31:0] wdata;
	} dsvm_obj_req_s;

	// object access answer
	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} dsvm_obj_rsp_s;

endpackage

// ### hdl/dsvm_top.sv
// drive status word, operating mode objects and profile velocity ramp
`timescale 1ns/1ps
`include "dsvm_defines.svh"

module dsvm_top (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   nrst,
	// object access from the network stack
	input  wire dsvm_pkg::dsvm_obj_req_s obj_in,
	output dsvm_pkg::dsvm_obj_rsp_s      obj_out,
	// power state machine
	input  wire logic                   selftest_done,
	input  wire logic                   leave_sod,
	input  wire dsvm_pkg::dsvm_pds_s     pds_in,
	// drive conditions
	input  wire logic                   hv_present,
	input  wire logic                   remote_in,
	input  wire logic                   limit_active,
	input  wire logic                   sto_active,
	input  wire logic [15:0]            warn_detail,
	// motion and status word
	output logic signed [31:0]          velocity_demand,
	output logic [15:0]                 status_word
);

	dsvm_pkg::dsvm_state_e state;
	dsvm_pkg::dsvm_state_e next_state;
	logic [15:0]        control;
	logic [7:0]         requested_mode;
	logic [7:0]         active_mode;
	logic signed [31:0] target_vel;
	logic [31:0]        accel;
	logic [31:0]        decel;
	logic [32:0]        ramp_acc;
	logic               tr_force;
	dsvm_pkg::dsvm_obj_rsp_s next_obj;

	function automatic logic usable_mode(input logic [7:0] code);
		usable_mode = (code == `DSVM_MODE_PV) || (code == `DSVM_MODE_ANALOG);
	endfunction

	// power state seen by this block
	wire in_selftest = (state == dsvm_pkg::ST_SELFTEST);
	wire in_sod      = (state == dsvm_pkg::ST_SOD);
	wire in_ext      = (state == dsvm_pkg::ST_EXT);
	wire op_enabled  = in_ext && pds_in.op_enabled;
	wire fault_now   = in_ext && pds_in.fault;
	wire halt_req    = control[`DSVM_CB_HALT];

	always_comb begin
		next_state = state;
		case (state)
			dsvm_pkg::ST_SELFTEST: if (selftest_done) next_state = dsvm_pkg::ST_SOD;
			dsvm_pkg::ST_SOD:      if (leave_sod) next_state = dsvm_pkg::ST_EXT;
			dsvm_pkg::ST_EXT:      if (pds_in.switch_on_disabled) next_state = dsvm_pkg::ST_SOD;
			default:               next_state = dsvm_pkg::ST_SELFTEST;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= dsvm_pkg::ST_SELFTEST;
		end else begin
			state <= next_state;
		end
	end

	// object access decode
	wire acc    = obj_in.req && !in_selftest;
	wire wr     = acc && obj_in.we;
	wire rd     = acc && !obj_in.we;
	wire i_ctl  = (obj_in.index == `DSVM_IDX_CONTROL);
	wire i_stat = (obj_in.index == `DSVM_IDX_STATUS);
	wire i_mreq = (obj_in.index == `DSVM_IDX_MODE_REQ);
	wire i_mact = (obj_in.index == `DSVM_IDX_MODE_ACT);
	wire i_vact = (obj_in.index == `DSVM_IDX_VEL_ACT);
	wire i_acc  = (obj_in.index == `DSVM_IDX_ACCEL);
	wire i_dec  = (obj_in.index == `DSVM_IDX_DECEL);
	wire i_tgt  = (obj_in.index == `DSVM_IDX_TARGET);
	wire i_warn = (obj_in.index == `DSVM_IDX_WARN);
	wire i_known = i_ctl || i_stat || i_mreq || i_mact || i_vact || i_acc || i_dec || i_tgt || i_warn;
	wire i_ro    = i_stat || i_mact || i_vact || i_warn;
	wire bad_mode = i_mreq && !usable_mode(obj_in.wdata[7:0]);
	wire wr_ok   = wr && i_known && !i_ro && !bad_mode;
	wire wr_tgt  = wr_ok && i_tgt;

	// mode acceptance: in operation enabled a change waits for halt
	wire mode_pending = (requested_mode != active_mode) && usable_mode(requested_mode);
	wire mode_accept  = mode_pending && (!op_enabled || halt_req);
	wire mode_change  = mode_accept;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			control        <= `DSVM_RST_CONTROL;
			requested_mode <= `DSVM_RST_MODE;
			accel          <= `DSVM_RST_RATE;
			decel          <= `DSVM_RST_RATE;
			target_vel     <= '0;
		end else begin
			if (wr_ok && i_ctl) control <= obj_in.wdata[15:0];
			if (wr_ok && i_mreq) requested_mode <= obj_in.wdata[7:0];
			if (wr_ok && i_acc) accel <= obj_in.wdata;
			if (wr_ok && i_dec) decel <= obj_in.wdata;
			if (wr_tgt) target_vel <= signed'(obj_in.wdata);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			active_mode <= `DSVM_MODE_NONE;
		end else if (mode_accept) begin
			active_mode <= requested_mode;
		end
	end

	// profile velocity ramp
	wire pv_run = op_enabled && (active_mode == `DSVM_MODE_PV);
	wire stop_req = halt_req || pds_in.quick_stop_active || (target_vel == 32'sh0);
	wire signed [31:0] goal = (pv_run && !stop_req) ? target_vel : 32'sh0;
	wire at_goal = (velocity_demand == goal);
	wire going_up = goal > velocity_demand;
	wire away = going_up ? (velocity_demand >= 32'sh0) : (velocity_demand <= 32'sh0);
	wire [31:0] rate = away ? accel : decel;
	wire [32:0] acc_sum = ramp_acc + {1'b0, rate};
	wire step = acc_sum >= 33'(`DSVM_CYC_PER_S);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			velocity_demand <= '0;
			ramp_acc        <= '0;
		end else if (fault_now || !op_enabled) begin
			velocity_demand <= '0;
			ramp_acc        <= '0;
		end else if (at_goal) begin
			ramp_acc <= '0;
		end else if (step) begin
			velocity_demand <= going_up ? velocity_demand + 32'sd1 : velocity_demand - 32'sd1;
			ramp_acc        <= acc_sum - 33'(`DSVM_CYC_PER_S);
		end else begin
			ramp_acc <= acc_sum;
		end
	end

	// target reached: forced after a mode change until the next target write
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tr_force <= 1'b0;
		end else if (mode_change) begin
			tr_force <= 1'b1;
		end else if (wr_tgt) begin
			tr_force <= 1'b0;
		end
	end

	wire tr_flag = tr_force || (velocity_demand == target_vel);

	// status word assembly
	logic [15:0] next_status;
	always_comb begin
		next_status = 16'h0000;
		if (in_sod) begin
			next_status[`DSVM_SB_SOD] = 1'b1;
			next_status[`DSVM_SB_QS_N] = 1'b1;
		end
		if (in_ext) begin
			next_status[`DSVM_SB_READY] = pds_in.ready;
			next_status[`DSVM_SB_SWON]  = pds_in.switched_on;
			next_status[`DSVM_SB_OPEN]  = pds_in.op_enabled;
			next_status[`DSVM_SB_FAULT] = pds_in.fault;
			next_status[`DSVM_SB_SOD]   = pds_in.switch_on_disabled;
			next_status[`DSVM_SB_QS_N]  = !pds_in.quick_stop_active;
			next_status[`DSVM_SB_DRV_FAULT] = pds_in.fault;
		end
		if (!in_selftest) begin
			next_status[`DSVM_SB_HV]       = hv_present;
			next_status[`DSVM_SB_WARN]     = |warn_detail;
			next_status[`DSVM_SB_REMOTE]   = remote_in;
			next_status[`DSVM_SB_TR]       = tr_flag;
			next_status[`DSVM_SB_LIMIT]    = limit_active;
			next_status[`DSVM_SB_ZERO_SPD] = (velocity_demand == 32'sh0);
			next_status[`DSVM_SB_SAFETY]   = sto_active;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			status_word <= 16'h0000;
		end else begin
			status_word <= next_status;
		end
	end

	// read data and answer
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (i_ctl) begin
			rd_mux = {16'h0000, control};
		end else if (i_stat) begin
			rd_mux = {16'h0000, next_status};
		end else if (i_mreq) begin
			rd_mux = {24'h000000, requested_mode};
		end else if (i_mact) begin
			rd_mux = {{24{active_mode[7]}}, active_mode};
		end else if (i_vact) begin
			rd_mux = velocity_demand;
		end else if (i_acc) begin
			rd_mux = accel;
		end else if (i_dec) begin
			rd_mux = decel;
		end else if (i_tgt) begin
			rd_mux = target_vel;
		end else if (i_warn) begin
			rd_mux = {16'h0000, warn_detail};
		end
	end

	always_comb begin
		next_obj.ack   = acc;
		next_obj.err   = acc && (!i_known || (obj_in.we && (i_ro || bad_mode)));
		next_obj.rdata = (rd && i_known) ? rd_mux : 32'h0000_0000;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			obj_out <= '0;
		end else begin
			obj_out <= next_obj;
		end
	end

endmodule

// ### tb/dsvm_props.sv
// assertions on the drive status block ports
`timescale 1ns/1ps
module dsvm_top_props (
	// clock and reset
	input wire logic                    clock,
	input wire logic                    nrst,
	// watched ports
	input wire dsvm_pkg::dsvm_obj_req_s obj_in,
	input wire dsvm_pkg::dsvm_obj_rsp_s obj_out,
	input wire dsvm_pkg::dsvm_pds_s     pds_in,
	input wire logic                    hv_present,
	input wire logic                    sto_active,
	input wire logic [15:0]             warn_detail,
	input wire logic signed [31:0]      velocity_demand,
	input wire logic [15:0]             status_word
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	wire live = status_word != 16'h0000;
	wire wr = obj_in.req && obj_in.we && live;
	chk_ack_after_req: assert property (obj_out.ack |-> $past(obj_in.req))
		else $error("ack without request");
	chk_ro_readback: assert property (wr && obj_in.index == 16'h6061 |=> obj_out.ack && obj_out.err)
		else $error("readback write not refused");
	chk_bad_mode: assert property (wr && obj_in.index == 16'h6060 && !(obj_in.wdata[7:0] inside {8'h01, 8'h03})
		|=> obj_out.ack && obj_out.err)
		else $error("unusable mode not refused");
	chk_hv_bit: assert property (live |-> status_word[4] == $past(hv_present))
		else $error("voltage bit wrong");
	chk_safety_bit: assert property (live |-> status_word[14] == $past(sto_active))
		else $error("safety bit wrong");
	chk_warn_bit: assert property (live |-> status_word[7] == (|$past(warn_detail)))
		else $error("warning bit wrong");
	chk_unused_bits: assert property (status_word[8] == 1'b0 && status_word[13] == 1'b0)
		else $error("unused status bit set");
	chk_fault_stop: assert property (pds_in.fault |=> velocity_demand == 32'sh0)
		else $error("demand not stopped on fault");
	chk_ramp_step: assert property (velocity_demand != 0 |->
		(velocity_demand - $past(velocity_demand)) inside {-1, 0, 1})
		else $error("ramp step too large");
endmodule
bind dsvm_top dsvm_top_props chk (.clock(clock), .nrst(nrst), .obj_in(obj_in), .obj_out(obj_out), .pds_in(pds_in),
	.hv_present(hv_present), .sto_active(sto_active), .warn_detail(warn_detail),
	.velocity_demand(velocity_demand), .status_word(status_word));

// ### tb/dsvm_master.sv
// network master model issuing object accesses
`timescale 1ns/1ps
module dsvm_master (
	// clock
	input wire logic                    clock,
	// object access
	output dsvm_pkg::dsvm_obj_req_s     req,
	input wire dsvm_pkg::dsvm_obj_rsp_s rsp
);
	initial req = '0;
	task automatic xfer(input logic we, input logic [15:0] ix, input logic [31:0] wd,
		output logic [31:0] rd, output logic er, output logic ok);
		ok = 1'b0;
		rd = '0;
		er = 1'b0;
		@(posedge clock);
		req <= '{1'b1, we, ix, wd};
		@(posedge clock);
		req <= '{1'b0, ~we, ~ix, ~wd};
		for (int n = 0; n < 3 && !ok; n++) begin
			@(posedge clock);
			if (rsp.ack === 1'b1) begin
				ok = 1'b1;
				rd = rsp.rdata;
				er = rsp.err;
			end
		end
	endtask
endmodule

// ### tb/tb.sv
// testbench of the drive status block
`timescale 1ns/1ps
module tb;
	logic                    clock, nrst, st_done, leave, hv, rem, lim, sto, er, ok;
	logic [15:0]             warn, sw;
	logic [31:0]             rd;
	logic signed [31:0]      vel;
	dsvm_pkg::dsvm_pds_s     pds;
	dsvm_pkg::dsvm_obj_req_s oreq;
	dsvm_pkg::dsvm_obj_rsp_s orsp;
	int                      fails = 0;
	int                      check_count = 0;
	dsvm_top uut (.clock(clock), .nrst(nrst), .obj_in(oreq), .obj_out(orsp), .selftest_done(st_done),
		.leave_sod(leave), .pds_in(pds), .hv_present(hv), .remote_in(rem), .limit_active(lim),
		.sto_active(sto), .warn_detail(warn), .velocity_demand(vel), .status_word(sw));
	dsvm_master mst (.clock(clock), .req(oreq), .rsp(orsp));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic we, input logic [15:0] ix, input logic [31:0] wd);
		mst.xfer(we, ix, wd, rd, er, ok);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic t_selftest();
		acc(1'b1, 16'h6060, 32'h3);
		chk("ack in self-test", 32'(ok), 32'h0);
		chk("status in self-test", 32'(sw), 32'h0);
		st_done <= 1'b1;
		cyc(2);
		$display("test selftest done");
	endtask
	task automatic t_status();
		hv <= 1'b1;
		rem <= 1'b1;
		lim <= 1'b1;
		sto <= 1'b1;
		warn <= 16'h0004;
		cyc(3);
		chk("status flags", 32'(sw & 16'hfbff), 32'h5af0);
		acc(1'b0, 16'h6041, 32'h0);
		chk("status read", rd & 32'hfbff, 32'h5af0);
		acc(1'b0, 16'h2003, 32'h0);
		chk("warning object", rd, 32'h4);
		acc(1'b1, 16'h6041, 32'h5);
		chk("status write err", 32'(er), 32'h1);
		hv <= 1'b0;
		sto <= 1'b0;
		warn <= 16'h0000;
		$display("test status done");
	endtask
	task automatic t_mode();
		logic [7:0] bad [4] = '{8'h00, 8'h02, 8'h0a, 8'hff};
		foreach (bad[i]) begin
			acc(1'b1, 16'h6060, 32'(bad[i]));
			chk("bad mode err", 32'(er), 32'h1);
		end
		acc(1'b1, 16'h6060, 32'h1);
		acc(1'b0, 16'h6061, 32'h0);
		chk("analog active", rd, 32'h1);
		acc(1'b1, 16'h6060, 32'h3);
		acc(1'b0, 16'h6060, 32'h0);
		chk("mode stored", rd, 32'h3);
		acc(1'b1, 16'h6061, 32'h1);
		chk("readback write err", 32'(er), 32'h1);
		acc(1'b0, 16'h6061, 32'h0);
		chk("pv active", rd, 32'h3);
		cyc(2);
		chk("reached on mode change", 32'(sw[10]), 32'h1);
		$display("test mode done");
	endtask
	task automatic t_motion();
		leave <= 1'b1;
		pds <= 6'b111000;
		cyc(2);
		leave <= 1'b0;
		acc(1'b1, 16'h6040, 32'h100);
		acc(1'b1, 16'h6060, 32'h1);
		acc(1'b1, 16'h6060, 32'h3);
		acc(1'b0, 16'h6061, 32'h0);
		chk("pv accepted", rd, 32'h3);
		acc(1'b1, 16'h6083, 32'h0ee6b280);
		acc(1'b1, 16'h6084, 32'h0ee6b280);
		acc(1'b1, 16'h6040, 32'h0);
		acc(1'b1, 16'h60ff, 32'h8);
		cyc(20);
		chk("ramp up", vel, 32'h8);
		chk("enabled bits", 32'(sw[2:0]), 32'h7);
		chk("reached", 32'(sw[10]), 32'h1);
		acc(1'b0, 16'h606c, 32'h0);
		chk("velocity read", rd, 32'h8);
		acc(1'b1, 16'h60ff, 32'h3);
		cyc(2);
		chk("reached cleared", 32'(sw[10]), 32'h0);
		cyc(20);
		chk("ramp down", vel, 32'h3);
		acc(1'b1, 16'h6040, 32'h100);
		cyc(20);
		chk("halted", vel, 32'h0);
		acc(1'b1, 16'h6040, 32'h0);
		cyc(20);
		chk("resumed", vel, 32'h3);
		acc(1'b1, 16'h60ff, 32'h0);
		cyc(20);
		chk("zero target", vel, 32'h0);
		$display("test motion done");
	endtask
	task automatic t_fault();
		acc(1'b1, 16'h60ff, 32'h8);
		cyc(20);
		pds <= 6'b111010;
		cyc(3);
		chk("quick stop bit", 32'(sw[5]), 32'h0);
		pds <= 6'b000100;
		cyc(2);
		chk("fault stop", vel, 32'h0);
		chk("fault bits", 32'({sw[15], sw[3]}), 32'h3);
		$display("test fault done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		cyc(3000);
		fails++;
		close_out();
	end
	initial begin
		{nrst, st_done, leave, hv, rem, lim, sto} = '0;
		warn = '0;
		pds = '0;
		cyc(16);
		nrst <= 1'b1;
		t_selftest();
		t_status();
		t_mode();
		t_motion();
		t_fault();
		close_out();
	end
endmodule
